/* verilog/fxr_pkg.sv */
// shared constants and types for the extended read register link
package fxr_pkg;
   // extended read register layout
   localparam logic [7:0] EXT_REG_RESET  = 8'hf0;
   localparam int         EXT_WIP_BIT    = 0;
   localparam int         EXT_PROT_BIT   = 1;
   localparam int         EXT_PROG_BIT   = 2;
   localparam int         EXT_ERASE_BIT  = 3;
   localparam int         EXT_RSVD_BIT   = 4;
   localparam int         EXT_ODS_LSB    = 5;
   localparam logic [2:0] ODS_RESET      = 3'h7;
   localparam logic       RSVD_VALUE     = 1'b1;

   // opcodes
   localparam logic [7:0] OP_SET_EXT_NV   = 8'h85;
   localparam logic [7:0] OP_SET_EXT_V    = 8'h83;
   localparam logic [7:0] OP_READ_EXT     = 8'h81;
   localparam logic [7:0] OP_CLEAR_EXT    = 8'h82;
   localparam logic [7:0] OP_SOFT_RESET   = 8'h99;
   localparam logic [7:0] OP_FAST_RD_A    = 8'h0b;
   localparam logic [7:0] OP_FAST_RD_B    = 8'h0c;
   localparam logic [7:0] OP_FAST_DTR_A   = 8'h0d;
   localparam logic [7:0] OP_FAST_DTR_B   = 8'h0e;
   localparam logic [7:0] OP_UNIQUE_ID    = 8'h4b;
   localparam logic [7:0] OP_PARAM_TABLE  = 8'h5a;
   localparam logic [7:0] OP_INFO_ROW     = 8'h68;
   localparam logic [7:0] OP_DUAL_OUT_A   = 8'h3b;
   localparam logic [7:0] OP_DUAL_OUT_B   = 8'h3c;
   localparam logic [7:0] OP_QUAD_OUT_A   = 8'h6b;
   localparam logic [7:0] OP_QUAD_OUT_B   = 8'h6c;
   localparam logic [7:0] OP_DUAL_IO_A    = 8'hbb;
   localparam logic [7:0] OP_DUAL_IO_B    = 8'hbc;
   localparam logic [7:0] OP_DUAL_DTR_A   = 8'hbd;
   localparam logic [7:0] OP_DUAL_DTR_B   = 8'hbe;
   localparam logic [7:0] OP_QUAD_IO_A    = 8'heb;
   localparam logic [7:0] OP_QUAD_IO_B    = 8'hec;
   localparam logic [7:0] OP_QUAD_DTR_A   = 8'hed;
   localparam logic [7:0] OP_QUAD_DTR_B   = 8'hee;

   // default dummy clocks
   localparam logic [3:0] DUMMY_NONE     = 4'h0;
   localparam logic [3:0] DUMMY_FOUR     = 4'h4;
   localparam logic [3:0] DUMMY_SIX      = 4'h6;
   localparam logic [3:0] DUMMY_EIGHT    = 4'h8;

   // link timing
   localparam int CORE_PERIOD_NS = 4;
   localparam int LINK_PERIOD_NS = 48;
   localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);

   // controller register map
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_TXDATA = 8'h04;
   localparam logic [7:0] REG_RXDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_MASK   = 8'h10;
   localparam int         CMD_HAS_DATA = 8;
   localparam int         CMD_HAS_READ = 9;
   localparam int         STS_DONE     = 0;
   localparam int         STS_ERROR    = 1;
   localparam int         STS_BUSY     = 2;

   typedef enum logic [4:0] {
      DEV_OFF  = 5'b00001,
      DEV_CMD  = 5'b00010,
      DEV_DATA = 5'b00100,
      DEV_SEND = 5'b01000,
      DEV_SKIP = 5'b10000
   } fxr_dev_state_e;

   typedef enum logic [2:0] {
      HST_IDLE = 3'b001,
      HST_XFER = 3'b010,
      HST_GAP  = 3'b100
   } fxr_hst_state_e;
endpackage

/* verilog/fxr_link_if.sv */
// serial link between controller and device
`timescale 1ns/1ps
interface fxr_link_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;

   modport ctrl (output sck, output cs_n, output mosi, input miso, input miso_oe);
   modport dev  (input sck, input cs_n, input mosi, output miso, output miso_oe);
endinterface

/* verilog/fxr_device.sv */
// device end: command decode and extended read register
`timescale 1ns/1ps

module fxr_device (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   input  wire logic         i_ce,
   fxr_link_if.dev           link,
   input  wire logic         i_busy,
   input  wire logic         i_quad_mode,
   input  wire logic         i_low_voltage,
   input  wire logic         i_prog_fail,
   input  wire logic         i_erase_fail,
   input  wire logic         i_prog_protected,
   input  wire logic         i_erase_protected,
   output logic              o_cmd_strobe,
   output logic [7:0]        o_cmd_opcode,
   output logic [3:0]        o_dummy_cycles,
   output logic              o_cmd_refused,
   output logic              o_nv_write,
   output logic [2:0]        o_drive_strength,
   output logic [2:0]        o_nv_drive_strength,
   output logic [7:0]        o_ext_reg
);
   import fxr_pkg::*;

   typedef struct packed {
      fxr_dev_state_e st;
      logic           sck1;
      logic           sck2;
      logic           sck3;
      logic           cs1;
      logic           cs2;
      logic           mosi1;
      logic           mosi2;
      logic [2:0]     cnt;
      logic [7:0]     sh;
      logic [7:0]     op;
      logic [7:0]     tx;
      logic           miso;
      logic           miso_oe;
      logic [2:0]     ods_v;
      logic [2:0]     ods_nv;
      logic           err_erase;
      logic           err_prog;
      logic           err_prot;
      logic           write_in_progress;
      logic           cmd_stb;
      logic [3:0]     dummy;
      logic           refused;
      logic           nv_wr;
   } fxr_dev_s;

   fxr_dev_s r;
   fxr_dev_s next_r;

   // {refused, dummy} for an opcode in the current lane mode
   function automatic logic [4:0] decode(input logic [7:0] op, input logic quad, input logic lv);
      logic [4:0] res;
      res = {1'b0, DUMMY_NONE};
      case (op)
         OP_FAST_RD_A, OP_FAST_RD_B, OP_FAST_DTR_A, OP_FAST_DTR_B,
         OP_UNIQUE_ID, OP_PARAM_TABLE, OP_INFO_ROW: begin
            res = {1'b0, quad ? DUMMY_SIX : DUMMY_EIGHT};
         end
         OP_DUAL_OUT_A, OP_DUAL_OUT_B, OP_QUAD_OUT_A, OP_QUAD_OUT_B: begin
            res = {quad, DUMMY_EIGHT};
         end
         OP_DUAL_IO_A, OP_DUAL_IO_B: begin
            res = {quad, DUMMY_FOUR};
         end
         OP_DUAL_DTR_A, OP_DUAL_DTR_B: begin
            res = {quad, DUMMY_FOUR};
         end
         OP_QUAD_IO_A, OP_QUAD_IO_B, OP_QUAD_DTR_A, OP_QUAD_DTR_B: begin
            res = {quad & lv, DUMMY_SIX};
         end
         default: begin
            res = {1'b0, DUMMY_NONE};
         end
      endcase
      return res;
   endfunction

   logic       sck_rise;
   logic       sck_fall;
   logic [7:0] byte_in;
   logic [7:0] ext_now;
   logic [4:0] dec;
   logic       clear_err;
   logic       soft_rst;

   always_comb begin
      next_r    = r;
      sck_rise  = r.sck2 & ~r.sck3;
      sck_fall  = ~r.sck2 & r.sck3;
      byte_in   = {r.sh[6:0], r.mosi2};
      dec       = decode(byte_in, i_quad_mode, i_low_voltage);
      clear_err = 1'b0;
      soft_rst  = 1'b0;
      ext_now   = {r.ods_v, RSVD_VALUE, r.err_erase, r.err_prog, r.err_prot, r.write_in_progress};

      // sck edges compare the second and third stages; cs_n and mosi use only the second stage
      next_r.sck1    = link.sck;
      next_r.sck2    = r.sck1;
      next_r.sck3    = r.sck2;
      next_r.cs1     = link.cs_n;
      next_r.cs2     = r.cs1;
      next_r.mosi1   = link.mosi;
      next_r.mosi2   = r.mosi1;
      next_r.write_in_progress     = i_busy;
      next_r.cmd_stb = 1'b0;
      next_r.refused = 1'b0;
      next_r.nv_wr   = 1'b0;

      if (r.cs2) begin
         next_r.st      = DEV_OFF;
         next_r.miso_oe = 1'b0;
      end else begin
         case (r.st)
            DEV_OFF: begin
               next_r.st  = DEV_CMD;
               next_r.cnt = 3'h0;
            end
            DEV_CMD: begin
               if (sck_rise) begin
                  next_r.sh  = byte_in;
                  next_r.cnt = r.cnt + 3'h1;
                  if (r.cnt == 3'h7) begin
                     // every opcode is decoded whatever the error flags say
                     next_r.op      = byte_in;
                     next_r.cmd_stb = 1'b1;
                     next_r.dummy   = dec[3:0];
                     next_r.refused = dec[4];
                     next_r.st      = DEV_SKIP;
                     case (byte_in)
                        OP_SET_EXT_NV, OP_SET_EXT_V: begin
                           next_r.st = DEV_DATA;
                        end
                        OP_READ_EXT: begin
                           next_r.tx = ext_now;
                           next_r.st = DEV_SEND;
                        end
                        OP_CLEAR_EXT: begin
                           clear_err = 1'b1;
                        end
                        OP_SOFT_RESET: begin
                           soft_rst  = 1'b1;
                           clear_err = 1'b1;
                        end
                        default: begin
                           next_r.st = DEV_SKIP;
                        end
                     endcase
                  end
               end
            end
            DEV_DATA: begin
               if (sck_rise) begin
                  next_r.sh  = byte_in;
                  next_r.cnt = r.cnt + 3'h1;
                  if (r.cnt == 3'h7) begin
                     next_r.st = DEV_SKIP;
                     // status bits of the data byte are dropped
                     if (r.op == OP_SET_EXT_NV) begin
                        next_r.ods_nv = byte_in[EXT_ODS_LSB +: 3];
                        next_r.nv_wr  = 1'b1;
                     end else begin
                        next_r.ods_v  = byte_in[EXT_ODS_LSB +: 3];
                     end
                  end
               end
            end
            DEV_SEND: begin
               // change on the falling edge so the host samples a settled bit
               if (sck_fall) begin
                  next_r.miso    = r.tx[7];
                  next_r.miso_oe = 1'b1;
                  next_r.tx      = {r.tx[6:0], r.tx[7]};
               end
            end
            DEV_SKIP: begin
               next_r.st = DEV_SKIP;
            end
            default: begin
               next_r.st = DEV_OFF;
            end
         endcase
      end

      if (soft_rst) begin
         next_r.ods_v = r.ods_nv;
      end
      if (clear_err) begin
         next_r.err_erase = 1'b0;
         next_r.err_prog  = 1'b0;
         next_r.err_prot  = 1'b0;
      end
      // set after clear so a fault in the clearing cycle survives
      if (i_prog_protected | i_erase_protected) begin
         next_r.err_prot = 1'b1;
      end
      if (i_prog_fail | i_prog_protected) begin
         next_r.err_prog = 1'b1;
      end
      if (i_erase_fail | i_erase_protected) begin
         next_r.err_erase = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         r         <= '0;
         r.st      <= DEV_OFF;
         r.sck1    <= 1'b0;
         r.sck2    <= 1'b0;
         r.sck3    <= 1'b0;
         r.cs1     <= 1'b1;
         r.cs2     <= 1'b1;
         r.ods_v   <= ODS_RESET;
         r.ods_nv  <= ODS_RESET;
      end else if (i_ce) begin
         r <= next_r;
      end
   end

   assign link.miso           = r.miso;
   assign link.miso_oe        = r.miso_oe;
   assign o_cmd_strobe        = r.cmd_stb;
   assign o_cmd_opcode        = r.op;
   assign o_dummy_cycles      = r.dummy;
   assign o_cmd_refused       = r.refused;
   assign o_nv_write          = r.nv_wr;
   assign o_drive_strength    = r.ods_v;
   assign o_nv_drive_strength = r.ods_nv;
   assign o_ext_reg           = {r.ods_v, RSVD_VALUE, r.err_erase, r.err_prog, r.err_prot, r.write_in_progress};
endmodule // fxr_device

/* verilog/fxr_host.sv */
// controller end: register port driving the serial link
`timescale 1ns/1ps
module fxr_host #(
   parameter int HALF_CYC = fxr_pkg::LINK_HALF_CYC
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   input  wire logic         i_ce,
   input  wire logic [7:0]   i_addr,
   input  wire logic [31:0]  i_wdata,
   input  wire logic         i_wr,
   input  wire logic         i_rd,
   output logic [31:0]       o_rdata,
   output logic              o_irq,
   fxr_link_if.ctrl          link
);
   import fxr_pkg::*;

   typedef struct packed {
      fxr_hst_state_e st;
      logic [7:0]     div;
      logic           sck;
      logic           cs_n;
      logic           mosi;
      logic [15:0]    sh;
      logic [4:0]     bitcnt;
      logic [4:0]     nbits;
      logic           has_read;
      logic [7:0]     txdata;
      logic [7:0]     rx;
      logic           miso1;
      logic           miso2;
      logic [1:0]     sts;
      logic [1:0]     mask;
      logic           irq;
      logic [31:0]    rdata;
   } fxr_hst_s;

   fxr_hst_s r;
   fxr_hst_s next_r;

   logic       tick;
   logic [4:0] nb;
   logic [1:0] ev;

   always_comb begin
      next_r       = r;
      next_r.miso1 = link.miso_oe ? link.miso : 1'b1;
      next_r.miso2 = r.miso1;
      next_r.rdata = 32'h0000_0000;
      tick         = (r.div == 8'(HALF_CYC - 1));
      ev           = 2'b00;
      nb           = 5'd8;

      case (r.st)
         HST_IDLE: begin
            next_r.div = 8'h00;
            if (i_wr && i_addr == REG_CMD) begin
               // the host must pick a legal command for the mode
               if (i_wdata[CMD_HAS_DATA] | i_wdata[CMD_HAS_READ]) begin
                  nb = 5'd16;
               end
               next_r.nbits    = nb;
               next_r.has_read = i_wdata[CMD_HAS_READ];
               next_r.sh       = {i_wdata[6:0], r.txdata, 1'b0};
               next_r.mosi     = i_wdata[7];
               next_r.cs_n     = 1'b0;
               next_r.sck      = 1'b0;
               next_r.bitcnt   = 5'd0;
               next_r.st       = HST_XFER;
            end
         end
         HST_XFER: begin
            next_r.div = tick ? 8'h00 : r.div + 8'h01;
            if (tick) begin
               next_r.sck = ~r.sck;
               if (r.sck) begin
                  // sample on the next falling edge, a full period after the edge that made the device drive the bit
                  next_r.rx     = {r.rx[6:0], r.miso2};
                  next_r.mosi   = r.sh[15];
                  next_r.sh     = {r.sh[14:0], 1'b0};
                  next_r.bitcnt = r.bitcnt + 5'd1;
                  if (r.bitcnt + 5'd1 == r.nbits) begin
                     next_r.cs_n = 1'b1;
                     next_r.st   = HST_GAP;
                  end
               end
            end
         end
         HST_GAP: begin
            next_r.div = r.div + 8'h01;
            if (tick) begin
               next_r.st  = HST_IDLE;
               ev[STS_DONE]  = 1'b1;
               ev[STS_ERROR] = r.has_read & (|r.rx[EXT_ERASE_BIT:EXT_PROT_BIT]);
            end
         end
         default: begin
            next_r.st = HST_IDLE;
         end
      endcase

      if (i_wr) begin
         case (i_addr)
            REG_TXDATA: next_r.txdata = i_wdata[7:0];
            REG_STATUS: next_r.sts    = r.sts & ~i_wdata[1:0];
            REG_MASK:   next_r.mask   = i_wdata[1:0];
            default:    next_r.txdata = next_r.txdata;
         endcase
      end
      // a new event wins over a clear in the same cycle
      next_r.sts = next_r.sts | ev;
      next_r.irq = |(next_r.sts & next_r.mask);

      if (i_rd) begin
         case (i_addr)
            REG_TXDATA: next_r.rdata = {24'h00_0000, r.txdata};
            REG_RXDATA: next_r.rdata = {24'h00_0000, r.rx};
            REG_STATUS: next_r.rdata = {29'h0000_0000, r.st != HST_IDLE, r.sts};
            REG_MASK:   next_r.rdata = {30'h0000_0000, r.mask};
            default:    next_r.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         r      <= '0;
         r.st   <= HST_IDLE;
         r.cs_n <= 1'b1;
         r.mosi <= 1'b1;
         r.miso1 <= 1'b1;
         r.miso2 <= 1'b1;
      end else if (i_ce) begin
         r <= next_r;
      end
   end

   assign link.sck  = r.sck;
   assign link.cs_n = r.cs_n;
   assign link.mosi = r.mosi;
   assign o_rdata   = r.rdata;
   assign o_irq     = r.irq;
endmodule // fxr_host

/* bench/fxr_assertions.sv */
// checker for the extended read register and command decode
`timescale 1ns/1ps
module fxr_assertions (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       miso_oe,
   input  wire logic       i_busy,
   input  wire logic       i_quad_mode,
   input  wire logic       i_low_voltage,
   input  wire logic       i_prog_fail,
   input  wire logic       i_erase_fail,
   input  wire logic       i_prog_protected,
   input  wire logic       i_erase_protected,
   input  wire logic       o_cmd_strobe,
   input  wire logic [7:0] o_cmd_opcode,
   input  wire logic       o_cmd_refused,
   input  wire logic [2:0] o_drive_strength,
   input  wire logic [7:0] o_ext_reg
);
   import fxr_pkg::*;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic [2:0] clr_win;
   logic       clr_now;
   logic       refuse_exp;
   assign clr_now = o_cmd_strobe && (o_cmd_opcode == OP_CLEAR_EXT || o_cmd_opcode == OP_SOFT_RESET);
   // clear may land a few cycles after the strobe
   always_ff @(posedge i_core_clk) begin
      if (i_rst)
         clr_win <= 3'h0;
      else if (clr_now)
         clr_win <= 3'h4;
      else if (clr_win != 3'h0)
         clr_win <= clr_win - 3'h1;
   end
   always_comb begin
      case (o_cmd_opcode)
         OP_DUAL_OUT_A, OP_DUAL_OUT_B, OP_QUAD_OUT_A, OP_QUAD_OUT_B,
         OP_DUAL_IO_A, OP_DUAL_IO_B, OP_DUAL_DTR_A, OP_DUAL_DTR_B: refuse_exp = i_quad_mode;
         OP_QUAD_IO_A, OP_QUAD_IO_B, OP_QUAD_DTR_A, OP_QUAD_DTR_B: refuse_exp = i_quad_mode && i_low_voltage;
         default: refuse_exp = 1'b0;
      endcase
   end
   property p_wip_mirror;
      !$past(i_rst) |-> o_ext_reg[EXT_WIP_BIT] == $past(i_busy);
   endproperty
   a_wip_mirror: assert property (p_wip_mirror) else $error("busy mirror wrong");
   property p_rsvd_one;
      o_ext_reg[EXT_RSVD_BIT] == RSVD_VALUE;
   endproperty
   a_rsvd_one: assert property (p_rsvd_one) else $error("reserved bit not one");
   property p_drive_field;
      o_ext_reg[7:5] == o_drive_strength &&
         ($stable(o_drive_strength) || o_cmd_opcode == OP_SET_EXT_V || o_cmd_opcode == OP_SOFT_RESET);
   endproperty
   a_drive_field: assert property (p_drive_field) else $error("drive field differs");
   property p_lane_release;
      $rose(cs_n) |-> ##[1:4] !miso_oe;
   endproperty
   a_lane_release: assert property (p_lane_release) else $error("data lane still driven");
   property p_refuse;
      o_cmd_strobe |-> o_cmd_refused == refuse_exp;
   endproperty
   a_refuse: assert property (p_refuse) else $error("refusal wrong");
   property p_sticky;
      (($past(o_ext_reg[3:1]) & ~o_ext_reg[3:1]) != 3'h0) |-> (clr_win != 3'h0 || clr_now);
   endproperty
   a_sticky: assert property (p_sticky) else $error("error bit dropped");
   property p_prog_err;
      i_prog_fail |-> ##[1:3] o_ext_reg[EXT_PROG_BIT];
   endproperty
   a_prog_err: assert property (p_prog_err) else $error("program error not set");
   property p_erase_err;
      i_erase_fail |-> ##[1:3] o_ext_reg[EXT_ERASE_BIT];
   endproperty
   a_erase_err: assert property (p_erase_err) else $error("erase error not set");
   property p_prog_prot;
      i_prog_protected |-> ##[1:3] (o_ext_reg[2:1] == 2'b11);
   endproperty
   a_prog_prot: assert property (p_prog_prot) else $error("program fault bits not set");
   property p_erase_prot;
      i_erase_protected |-> ##[1:3] (o_ext_reg[3] && o_ext_reg[1]);
   endproperty
   a_erase_prot: assert property (p_erase_prot) else $error("erase fault bits not set");
   c_frame: cover property ($fell(cs_n) ##[1:40] sck);
endmodule // fxr_assertions

/* bench/tb.sv */
// bench top: controller and device joined over the link
`timescale 1ns/1ps
module tb;
   import fxr_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic        busy     = 1'b0;
   logic        quad     = 1'b0;
   logic        lowv     = 1'b0;
   logic [3:0]  fault    = 4'h0;
   logic [7:0]  addr     = 8'h00;
   logic [31:0] wdata    = 32'h0000_0000;
   logic        wr       = 1'b0;
   logic        rd       = 1'b0;
   logic [31:0] rdata, rs;
   logic        irq, strobe, refused, nvw;
   logic [7:0]  opcode, ext, rx, d;
   logic [3:0]  dummy;
   logic [2:0]  drv, nvdrv;
   logic        seen_ref = 1'b0;
   int          nv_pulses = 0;
   int          fail_count = 0;
   int          total_checks = 0;
   int          seed = 35;
   logic [7:0]  ops [20] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h4b, 8'h5a, 8'h68, 8'h3b, 8'h3c, 8'h6b,
                            8'h6c, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'heb, 8'hec, 8'hed, 8'hee, 8'h82};

   always #2 core_clk = ~core_clk;
   // refusal flag of the latest opcode strobe, and count of stored-copy writes
   always @(posedge core_clk) if (strobe === 1'b1) seen_ref <= refused;
   always @(posedge core_clk) if (nvw === 1'b1) nv_pulses <= nv_pulses + 1;

   fxr_link_if link ();
   fxr_host u_fxr_host (.i_core_clk(core_clk), .i_rst(rst), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .link(link.ctrl));
   fxr_device u_fxr_device (.i_core_clk(core_clk), .i_rst(rst), .i_ce(1'b1), .link(link.dev), .i_busy(busy),
      .i_quad_mode(quad), .i_low_voltage(lowv), .i_prog_fail(fault[3]), .i_erase_fail(fault[2]),
      .i_prog_protected(fault[1]), .i_erase_protected(fault[0]), .o_cmd_strobe(strobe), .o_cmd_opcode(opcode),
      .o_dummy_cycles(dummy), .o_cmd_refused(refused), .o_nv_write(nvw), .o_drive_strength(drv),
      .o_nv_drive_strength(nvdrv), .o_ext_reg(ext));
   fxr_assertions u_fxr_assertions (.i_core_clk(core_clk), .i_rst(rst), .sck(link.sck), .cs_n(link.cs_n),
      .miso_oe(link.miso_oe), .i_busy(busy), .i_quad_mode(quad), .i_low_voltage(lowv), .i_prog_fail(fault[3]),
      .i_erase_fail(fault[2]), .i_prog_protected(fault[1]), .i_erase_protected(fault[0]),
      .o_cmd_strobe(strobe), .o_cmd_opcode(opcode), .o_cmd_refused(refused), .o_drive_strength(drv),
      .o_ext_reg(ext));

   function automatic logic [3:0] exp_dummy(input logic [7:0] op, input logic q);
      case (op)
         8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h4b, 8'h5a, 8'h68: exp_dummy = q ? DUMMY_SIX : DUMMY_EIGHT;
         8'h3b, 8'h3c, 8'h6b, 8'h6c: exp_dummy = DUMMY_EIGHT;
         8'hbb, 8'hbc, 8'hbd, 8'hbe: exp_dummy = DUMMY_FOUR;
         8'heb, 8'hec, 8'hed, 8'hee: exp_dummy = DUMMY_SIX;
         default: exp_dummy = DUMMY_NONE;
      endcase
   endfunction

   function automatic logic exp_ref(input logic [7:0] op, input logic q, input logic lv);
      case (op)
         8'h3b, 8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'hbd, 8'hbe: exp_ref = q;
         8'heb, 8'hec, 8'hed, 8'hee: exp_ref = q & lv;
         default: exp_ref = 1'b0;
      endcase
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   // flags: bit0 sends the data byte, bit1 reads one byte back
   task automatic run_cmd(input logic [7:0] op, input logic [1:0] fl, input logic [7:0] db, output logic [7:0] r);
      logic [31:0] s;
      s = 32'h0000_0000;
      reg_wr(REG_STATUS, 32'h0000_0003);
      reg_wr(REG_TXDATA, {24'h00_0000, db});
      reg_wr(REG_CMD, {22'h00_0000, fl, op});
      reg_rd(REG_STATUS, s);
      check("busy flag", 1'b1, s[STS_BUSY]);
      for (int n = 0; n < 300 && s[STS_DONE] !== 1'b1; n++)
         reg_rd(REG_STATUS, s);
      if (s[STS_DONE] !== 1'b1) begin
         fail_count++;
         $display("MISMATCH done expected 1 seen %b", s[STS_DONE]);
         final_report();
      end
      reg_rd(REG_RXDATA, s);
      r = s[7:0];
      repeat (4) @(posedge core_clk);
      #1;
   endtask

   task automatic err_pulse(input logic [3:0] v, input logic [2:0] exp);
      @(posedge core_clk);
      fault <= v;
      @(posedge core_clk);
      fault <= 4'h0;
      repeat (3) @(posedge core_clk);
      #1;
      check("error bits", exp, ext[3:1]);
   endtask

   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      check("ext_reg reset", EXT_REG_RESET, ext);
      check("drive reset", ODS_RESET, drv);
      check("stored drive reset", ODS_RESET, nvdrv);
      reg_rd(8'h14, rs);
      check("unmapped read", 32'h0000_0000, rs);
      run_cmd(OP_READ_EXT, 2'b10, 8'h00, rx);
      check("ext_reg over link", EXT_REG_RESET, rx);
      for (int m = 0; m < 3; m++) begin
         @(posedge core_clk);
         quad <= (m != 0);
         lowv <= (m == 2);
         foreach (ops[i]) begin
            run_cmd(ops[i], 2'b00, 8'h00, rx);
            check("opcode", ops[i], opcode);
            check("refused", exp_ref(ops[i], quad, lowv), seen_ref);
            check("dummy count", exp_dummy(ops[i], quad), dummy);
         end
      end
      @(posedge core_clk);
      quad <= 1'b0;
      lowv <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         d = (k == 0) ? 8'h0f : 8'($random(seed));
         run_cmd(OP_SET_EXT_V, 2'b01, d, rx);
         check("working drive", d[7:5], drv);
         check("status bits kept", 4'h0, ext[3:0]);
         check("stored drive kept", ODS_RESET, nvdrv);
         check("no stored write", 32'h0000_0000, nv_pulses);
         run_cmd(OP_READ_EXT, 2'b10, 8'h00, rx);
         check("ext_reg readback", {d[7:5], 5'h10}, rx);
      end
      run_cmd(OP_SET_EXT_NV, 2'b01, 8'h2a, rx);
      check("stored drive", 3'h1, nvdrv);
      check("stored write pulse", 32'h0000_0001, nv_pulses);
      reg_rd(REG_TXDATA, rs);
      check("txdata readback", 32'h0000_002a, rs);
      check("working drive held", d[7:5], drv);
      run_cmd(OP_SOFT_RESET, 2'b00, 8'h00, rx);
      check("drive reload", 3'h1, drv);
      err_pulse(4'h8, 3'h2);
      @(posedge core_clk);
      busy <= 1'b1;
      err_pulse(4'h1, 3'h7);
      run_cmd(OP_READ_EXT, 2'b10, 8'h00, rx);
      check("ext_reg with errors", 8'h3f, rx);
      check("irq masked", 1'b0, irq);
      reg_wr(REG_MASK, 32'h0000_0002);
      repeat (2) @(posedge core_clk);
      #1;
      check("irq raised", 1'b1, irq);
      reg_rd(REG_MASK, rs);
      check("mask readback", 32'h0000_0002, rs);
      reg_wr(REG_STATUS, 32'h0000_0002);
      repeat (2) @(posedge core_clk);
      #1;
      check("irq cleared", 1'b0, irq);
      @(posedge core_clk);
      busy <= 1'b0;
      run_cmd(OP_CLEAR_EXT, 2'b00, 8'h00, rx);
      check("errors cleared", 3'h0, ext[3:1]);
      err_pulse(4'h2, 3'h3);
      err_pulse(4'h4, 3'h7);
      run_cmd(OP_SOFT_RESET, 2'b00, 8'h00, rx);
      check("errors reset", 3'h0, ext[3:1]);
      // hardware reset in mid-run with an error pending
      err_pulse(4'h4, 3'h4);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      check("ext_reg after reset", EXT_REG_RESET, ext);
      check("stored drive after reset", ODS_RESET, nvdrv);
      final_report();
   end
endmodule // tb
